/* File: logic/aboe_defines.svh */
// Purpose: offsets, field positions, reset values for the add/bit-op execute unit
// Assumes: 32-bit avalon data, byte addresses
// Notes: definitions only
`ifndef ABOE_DEFINES_SVH
`define ABOE_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ABOE_CMD_OFS 5'h00
`define ABOE_ACC_OFS 5'h04
`define ABOE_STAT_OFS 5'h08
`define ABOE_FPTR_OFS 5'h0C
`define ABOE_FDATA_OFS 5'h10

// ****************************************
// command word fields
// ****************************************
`define ABOE_CMD_OP_LSB 0
`define ABOE_CMD_OP_MSB 2
`define ABOE_CMD_DEST_BIT 3
`define ABOE_CMD_ADDR_LSB 4
`define ABOE_CMD_ADDR_MSB 10
`define ABOE_CMD_BIT_LSB 11
`define ABOE_CMD_BIT_MSB 13
`define ABOE_CMD_LIT_LSB 16
`define ABOE_CMD_LIT_MSB 23

// ****************************************
// status fields and reset values
// ****************************************
`define ABOE_ST_CARRY 0
`define ABOE_ST_DC 1
`define ABOE_ST_ZERO 2
`define ABOE_ST_SKIP 3
`define ABOE_ACC_RST 8'h00
`define ABOE_PORT_ADDR 7'h06

`endif

/* File: logic/aboe_pkg.sv */
// Purpose: types of the add/bit-op execute unit
// Assumes: nothing
// Notes: op order is the command field encoding
package aboe_pkg;
    typedef enum logic [2:0] {
        add_literal_to_acc,
        add_acc_and_file,
        and_literal_with_acc,
        and_acc_with_file,
        bit_clear_op,
        bit_set_op,
        skip_if_bit_set_op,
        skip_if_bit_clear_op
    } aboe_op_e;
    typedef logic [7:0] aboe_byte_t;
endpackage

/* File: logic/aboe_exec.sv */
// Purpose: execute unit for literal/file add, and, bit clear/set and bit-test skips
// Assumes: avalon-mm slave on mclk, one command per CMD write
// Notes: a true skip makes the next command write a discarded nop
//
// What this block does
// RULE1 - literal add into accumulator, flags updated
// RULE2 - accumulator plus file register, flags updated
// RULE3 - destination bit: 0 accumulator, 1 file
// RULE4 - literal and into accumulator, zero only
// RULE5 - file and, routed by destination, zero only
// RULE6 - bit clear in file, no flags
// RULE7 - bit set in file, no flags
// RULE8 - skip-if-set: bit one discards next instruction
// RULE9 - skip-if-clear: bit zero discards next instruction
// RULE10 - port read-modify-write uses pin levels
// RULE11 - carry bit7, digit carry bit3, zero result
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aboe_defines.svh"

module aboe_exec #(
    parameter int DEPTH = 128
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_latch,
    output logic skip_pending
);

    // ****************************************
    // functions
    // ****************************************
    function automatic aboe_pkg::aboe_byte_t bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    // ****************************************
    // state
    // ****************************************
    aboe_pkg::aboe_byte_t mem [DEPTH];
    logic [7:0] acc_ff, port_latch_ff, pins_meta_ff, pins_sync_ff;
    logic carry_ff, dc_ff, zero_ff, skip_ff, wait_ff;
    logic [6:0] fptr_ff;
    logic [31:0] rdata_ff;

    // ****************************************
    // bus decode
    // ****************************************
    wire logic wr_take = avs_write & ~wait_ff;
    wire logic wr_cmd = wr_take && avs_address == `ABOE_CMD_OFS;
    wire logic wr_acc = wr_take && avs_address == `ABOE_ACC_OFS;
    wire logic wr_stat = wr_take && avs_address == `ABOE_STAT_OFS;
    wire logic wr_fptr = wr_take && avs_address == `ABOE_FPTR_OFS;
    wire logic wr_fdata = wr_take && avs_address == `ABOE_FDATA_OFS;
    // discarded slot: the next command after a true skip runs as a nop
    wire logic exec = wr_cmd & ~skip_ff; // RULE8 RULE9

    // ****************************************
    // command fields and operand
    // ****************************************
    wire aboe_pkg::aboe_op_e op = aboe_pkg::aboe_op_e'(avs_writedata[`ABOE_CMD_OP_MSB:`ABOE_CMD_OP_LSB]);
    wire logic dest = avs_writedata[`ABOE_CMD_DEST_BIT];
    wire logic [6:0] faddr = avs_writedata[`ABOE_CMD_ADDR_MSB:`ABOE_CMD_ADDR_LSB];
    wire logic [2:0] bidx = avs_writedata[`ABOE_CMD_BIT_MSB:`ABOE_CMD_BIT_LSB];
    wire logic [7:0] lit = avs_writedata[`ABOE_CMD_LIT_MSB:`ABOE_CMD_LIT_LSB];
    wire logic is_port = faddr == `ABOE_PORT_ADDR;
    // pins, not the latch, feed every port read-modify-write
    wire logic [7:0] fval = is_port ? pins_sync_ff : mem[faddr]; // RULE10
    wire logic is_lit = op == aboe_pkg::add_literal_to_acc || op == aboe_pkg::and_literal_with_acc;
    wire logic is_add = op == aboe_pkg::add_literal_to_acc || op == aboe_pkg::add_acc_and_file;
    wire logic is_and = op == aboe_pkg::and_literal_with_acc || op == aboe_pkg::and_acc_with_file;
    wire logic [7:0] opnd = is_lit ? lit : fval; // RULE1 RULE4

    // ****************************************
    // alu
    // ****************************************
    wire logic [4:0] lo_sum = {1'b0, acc_ff[3:0]} + {1'b0, opnd[3:0]}; // RULE11
    wire logic [8:0] sum9 = {1'b0, acc_ff} + {1'b0, opnd}; // RULE1 RULE2
    wire logic [7:0] and8 = acc_ff & opnd; // RULE4 RULE5
    wire logic [7:0] mask = bit_mask(bidx);
    wire logic tbit = |(fval & mask);
    wire logic [7:0] res = is_add ? sum9[7:0] : (is_and ? and8 : 8'h00);
    wire logic to_file_alu = (is_add | is_and) & ~is_lit & dest; // RULE3
    wire logic to_acc = (is_add | is_and) & ~to_file_alu; // RULE3
    wire logic bit_wr = op == aboe_pkg::bit_clear_op || op == aboe_pkg::bit_set_op;
    wire logic [7:0] bit_res = (op == aboe_pkg::bit_set_op) ? (fval | mask) : (fval & ~mask); // RULE6 RULE7
    wire logic file_we = exec & (to_file_alu | bit_wr);
    wire logic [7:0] file_wd = bit_wr ? bit_res : res;
    wire logic skip_hit = (op == aboe_pkg::skip_if_bit_set_op && tbit) ||
                          (op == aboe_pkg::skip_if_bit_clear_op && !tbit); // RULE8 RULE9

    // ****************************************
    // next values
    // ****************************************
    wire logic [7:0] nxt_acc = (exec & to_acc) ? res : (wr_acc ? avs_writedata[7:0] : acc_ff);
    wire logic nxt_carry = (exec & is_add) ? sum9[8] : (wr_stat ? avs_writedata[`ABOE_ST_CARRY] : carry_ff);
    wire logic nxt_dc = (exec & is_add) ? lo_sum[4] : (wr_stat ? avs_writedata[`ABOE_ST_DC] : dc_ff);
    wire logic nxt_zero = (exec & (is_add | is_and)) ? (res == 8'h00) :
                          (wr_stat ? avs_writedata[`ABOE_ST_ZERO] : zero_ff); // RULE11
    wire logic nxt_skip = wr_cmd ? (exec & skip_hit) : skip_ff;
    wire logic [7:0] fd_rd = (fptr_ff == `ABOE_PORT_ADDR) ? pins_sync_ff : mem[fptr_ff];
    wire logic [31:0] nxt_rdata = (avs_address == `ABOE_ACC_OFS) ? {24'h0, acc_ff} :
                                  (avs_address == `ABOE_STAT_OFS) ? {28'h0, skip_ff, zero_ff, dc_ff, carry_ff} :
                                  (avs_address == `ABOE_FPTR_OFS) ? {25'h0, fptr_ff} :
                                  (avs_address == `ABOE_FDATA_OFS) ? {24'h0, fd_rd} : 32'h0;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
            acc_ff <= `ABOE_ACC_RST;
            carry_ff <= 1'b0;
            dc_ff <= 1'b0;
            zero_ff <= 1'b0;
            skip_ff <= 1'b0;
            fptr_ff <= 7'h00;
            port_latch_ff <= 8'h00;
            pins_meta_ff <= 8'h00;
            pins_sync_ff <= 8'h00;
        end else begin
            wait_ff <= ~((avs_read | avs_write) & wait_ff);
            rdata_ff <= (avs_read & wait_ff) ? nxt_rdata : rdata_ff;
            acc_ff <= nxt_acc;
            carry_ff <= nxt_carry;
            dc_ff <= nxt_dc;
            zero_ff <= nxt_zero;
            skip_ff <= nxt_skip;
            fptr_ff <= wr_fptr ? avs_writedata[6:0] : fptr_ff;
            pins_meta_ff <= port_pins;
            pins_sync_ff <= pins_meta_ff;
            if ((file_we && is_port) || (wr_fdata && fptr_ff == `ABOE_PORT_ADDR)) begin
                port_latch_ff <= file_we ? file_wd : avs_writedata[7:0];
            end
        end
    end

    // file storage carries no reset, like any register file
    always_ff @(posedge mclk) begin
        if (file_we) begin
            mem[faddr] <= file_wd; // RULE2 RULE5 RULE6 RULE7
        end else if (wr_fdata) begin
            mem[fptr_ff] <= avs_writedata[7:0];
        end
    end

    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;
    assign port_latch = port_latch_ff;
    assign skip_pending = skip_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_true_skip;
        exec && !is_lit && skip_hit && (op == aboe_pkg::skip_if_bit_set_op || op == aboe_pkg::skip_if_bit_clear_op);
    endsequence
    // an armed skip waits for the next command write, however late it comes
    sequence s_armed_idle;
        skip_ff && !wr_cmd;
    endsequence

    a_add_literal_sum: assert property (exec && op == aboe_pkg::add_literal_to_acc |=> // RULE1
        acc_ff == 8'($past(acc_ff) + $past(lit))) else $error("literal add result wrong");
    a_add_file_flags: assert property (exec && op == aboe_pkg::add_acc_and_file |=> // RULE2
        carry_ff == $past(sum9[8]) && dc_ff == $past(lo_sum[4])) else $error("file add flags wrong");
    a_dest_file_acc: assert property (exec && to_file_alu |=> // RULE3
        $stable(acc_ff) && mem[$past(faddr)] == $past(res)) else $error("file destination mishandled");
    a_and_literal_flags: assert property (exec && op == aboe_pkg::and_literal_with_acc |=> // RULE4
        acc_ff == ($past(acc_ff) & $past(lit)) && $stable(carry_ff) && $stable(dc_ff))
        else $error("literal and wrong");
    a_and_file_zero: assert property (exec && op == aboe_pkg::and_acc_with_file |=> // RULE5
        zero_ff == ($past(and8) == 8'h00) && $stable(carry_ff)) else $error("file and wrong");
    a_bit_clear_val: assert property (exec && op == aboe_pkg::bit_clear_op && !is_port |=> // RULE6
        (mem[$past(faddr)] & $past(mask)) == 8'h00 && $stable(zero_ff)) else $error("bit clear wrong");
    a_bit_set_val: assert property (exec && op == aboe_pkg::bit_set_op && !is_port |=> // RULE7
        (mem[$past(faddr)] & $past(mask)) != 8'h00 && $stable(carry_ff) && $stable(zero_ff))
        else $error("bit set wrong");
    a_skip_set_nop: assert property (s_true_skip ##0 (op == aboe_pkg::skip_if_bit_set_op) |=> // RULE8
        skip_ff) else $error("skip-if-set did not arm");
    a_skip_held: assert property (s_armed_idle |=> skip_ff) // RULE8 RULE9
        else $error("armed skip lost before next command");
    a_skip_discard: assert property (wr_cmd && skip_ff |=> !skip_ff && $stable(acc_ff) && // RULE8 RULE9
        $stable(zero_ff)) else $error("discarded slot changed state");
    a_skip_clear_arm: assert property (exec && op == aboe_pkg::skip_if_bit_clear_op |=> // RULE9
        skip_ff == !$past(tbit) && $stable(zero_ff)) else $error("skip-if-clear wrong");
    a_port_pin_operand: assert property (exec && is_port && op == aboe_pkg::bit_set_op |=> // RULE10
        port_latch_ff == ($past(pins_sync_ff) | $past(mask))) else $error("port operand not from pins");
    a_zero_result: assert property (exec && to_acc |=> zero_ff == (acc_ff == 8'h00)) // RULE11
        else $error("zero flag wrong");

    // ****************************************
    // assertions: flags, discard and bus
    // ****************************************
    // flags recomputed from the operands, not from the adder wires
    a_add_literal_flags: assert property (exec && op == aboe_pkg::add_literal_to_acc |=> // RULE1 RULE11
        carry_ff == (({1'b0, $past(acc_ff)} + {1'b0, $past(lit)}) > 9'h0FF) &&
        dc_ff == (({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(lit[3:0])}) > 5'h0F))
        else $error("literal add flags wrong");
    a_bit_ops_flags: assert property (exec && bit_wr |=> // RULE6 RULE7
        $stable(carry_ff) && $stable(dc_ff) && $stable(zero_ff)) else $error("bit op changed flags");
    a_skip_no_state: assert property (s_true_skip |=> // RULE8 RULE9
        $stable(acc_ff) && $stable(carry_ff) && $stable(dc_ff)) else $error("skip test changed state");
    a_discard_no_write: assert property (wr_cmd && skip_ff |-> !file_we && !exec) // RULE8 RULE9
        else $error("discarded slot wrote the file");
    // one wait state: the answer follows the cycle in which the request is seen
    a_bus_one_wait: assert property ((avs_read | avs_write) && wait_ff |=> !wait_ff)
        else $error("waitrequest not dropped");

endmodule

`default_nettype wire

/* File: dv/aboe_pins_model.sv */
// Purpose: far-side model of the port pins
// Assumes: an outside device may pull pins low
// Notes: pins follow the latch unless pulled low
`timescale 1ns/1ps
`default_nettype none
module aboe_pins_model (
    input wire logic [7:0] port_latch,
    input wire logic [7:0] pull_low,
    output logic [7:0] port_pins
);
    // pin level can differ from latch, so rmw must use pins
    assign port_pins = port_latch & ~pull_low;
endmodule
`default_nettype wire

/* File: dv/aboe_exec_tb.sv */
// Purpose: self-checking bench of the execute unit
// Assumes: one wait state per access, skip discards next cmd
// Notes: random ops on eight file slots plus port corner cases
`timescale 1ns/1ps
`default_nettype none
`include "aboe_defines.svh"
module aboe_exec_tb;
    // ****************************************
    // signals and model state
    // ****************************************
    logic mclk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rv, sd = 32'h46E51D7B;
    logic avs_waitrequest, skip_pending;
    logic [7:0] port_pins, port_latch, pull_low = 8'h00;
    logic [7:0] acc = 8'h00, lat = 8'h00, fm [0:127];
    logic c = 1'b0, dc = 1'b0, z = 1'b0, skp = 1'b0;
    int num_errors = 0, checks_done = 0;
    aboe_exec dut_u (.mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_pins(port_pins), .port_latch(port_latch),
        .skip_pending(skip_pending));
    aboe_pins_model pm_u (.port_latch(port_latch), .pull_low(pull_low), .port_pins(port_pins));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic void model(input logic [2:0] op, input logic d, input logic [6:0] a,
        input logic [2:0] b, input logic [7:0] k);
        logic [8:0] s;
        logic [7:0] x, r;
        x = (a == `ABOE_PORT_ADDR) ? (lat & ~pull_low) : fm[a];
        if (op == 3'd0 || op == 3'd2) x = k;
        r = 8'h00;
        if (skp) begin
            skp = 1'b0;
            return;
        end
        case (op)
            3'd0, 3'd1: begin
                s = {1'b0, acc} + {1'b0, x};
                dc = ({1'b0, acc[3:0]} + {1'b0, x[3:0]}) > 5'h0F;
                c = s[8];
                r = s[7:0];
                z = (r == 8'h00);
            end
            3'd2, 3'd3: begin
                r = acc & x;
                z = (r == 8'h00);
            end
            3'd4: r = x & ~(8'h01 << b);
            3'd5: r = x | (8'h01 << b);
            3'd6: skp = x[b];
            default: skp = !x[b];
        endcase
        if (op == 3'd0 || op == 3'd2 || ((op == 3'd1 || op == 3'd3) && !d)) acc = r;
        else if (op < 3'd6 && a == `ABOE_PORT_ADDR) lat = r;
        else if (op < 3'd6) fm[a] = r;
    endfunction
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        chk("wait states", 32'h2, 32'(n));
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic cmd(input logic [2:0] op, input logic d, input logic [6:0] a, input logic [2:0] b,
        input logic [7:0] k);
        repeat (3) @(posedge mclk);
        model(op, d, a, b, k);
        bus(1'b1, `ABOE_CMD_OFS, {8'h00, k, 2'b00, b, a, d, op});
        bus(1'b0, `ABOE_ACC_OFS, 32'h0);
        chk("acc", {24'h0, acc}, rv);
        bus(1'b0, `ABOE_STAT_OFS, 32'h0);
        chk("status", {28'h0, skp, z, dc, c}, rv);
        chk("skip_pending", {31'h0, skp}, {31'h0, skip_pending});
        chk("port_latch", {24'h0, lat}, {24'h0, port_latch});
        bus(1'b1, `ABOE_FPTR_OFS, {25'h0, a});
        bus(1'b0, `ABOE_FDATA_OFS, 32'h0);
        if (a != `ABOE_PORT_ADDR) chk("file", {24'h0, fm[a]}, rv);
        else chk("port pins", {24'h0, lat & ~pull_low}, rv);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        results();
    end
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            sd = lfsr(sd);
            fm[7'h20 + i] = sd[7:0];
            bus(1'b1, `ABOE_FPTR_OFS, 32'h20 + i);
            bus(1'b1, `ABOE_FDATA_OFS, {24'h0, sd[7:0]});
        end
        bus(1'b1, `ABOE_ACC_OFS, 32'h01);
        acc = 8'h01;
        cmd(3'd0, 1'b0, 7'h20, 3'd0, 8'hFF);
        cmd(3'd0, 1'b0, 7'h20, 3'd0, 8'h08);
        cmd(3'd0, 1'b0, 7'h20, 3'd0, 8'h08);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, rv);
        $display("test corner done");
        pull_low <= 8'h0F;
        cmd(3'd5, 1'b0, `ABOE_PORT_ADDR, 3'd7, 8'h00);
        cmd(3'd5, 1'b0, `ABOE_PORT_ADDR, 3'd0, 8'h00);
        cmd(3'd4, 1'b0, `ABOE_PORT_ADDR, 3'd7, 8'h00);
        $display("test port done");
        bus(1'b1, `ABOE_STAT_OFS, 32'h0000000F);
        {z, dc, c} = 3'h7;
        bus(1'b0, `ABOE_STAT_OFS, 32'h0);
        chk("status write", {28'h0, skp, z, dc, c}, rv);
        nrst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("reset wait", 32'h1, {31'h0, avs_waitrequest});
        chk("reset latch", 32'h0, {24'h0, port_latch});
        nrst <= 1'b1;
        {acc, lat, c, dc, z, skp} = 20'h0;
        bus(1'b0, `ABOE_ACC_OFS, 32'h0);
        chk("reset acc", 32'h0, rv);
        bus(1'b0, `ABOE_STAT_OFS, 32'h0);
        chk("reset status", 32'h0, rv);
        $display("test reset done");
        for (int i = 0; i < 120; i++) begin
            sd = lfsr(sd);
            cmd(sd[2:0], sd[3], 7'h20 + sd[6:4], sd[10:8], sd[23:16]);
        end
        $display("test random done");
        results();
    end
endmodule
`default_nettype wire
